// ===== pkg/bcfg_pkg.sv
// Constants, types and helpers of the bus configuration register block.
// Assumes a Wishbone classic master with 32-bit data and a flash link clock
// far slower than clk.
package bcfg_pkg;

    // ------------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------------
    localparam logic [7:0]  BCFG_OFS_NONVOL = 8'h00;
    localparam logic [7:0]  BCFG_OFS_VOL    = 8'h04;
    localparam logic [7:0]  BCFG_OFS_CTRL   = 8'h08;
    localparam logic [7:0]  BCFG_OFS_STAT   = 8'h0c;
    localparam logic [7:0]  BCFG_OFS_BSET   = 8'h10;
    localparam logic [7:0]  BCFG_OFS_BADDR  = 8'h14;

    // ------------------------------------------------------------------
    // Values after reset and field positions
    // ------------------------------------------------------------------
    localparam logic [15:0] BCFG_FACTORY    = 16'h8ebb;
    localparam logic [15:0] BCFG_ERASED     = 16'hffff;
    localparam logic [15:0] BCFG_RSV_ONES   = 16'h8008;
    localparam logic [15:0] BCFG_WORD_RST   = 16'h0000;
    localparam logic [4:0]  BCFG_LAT_BASE   = 5'h05;
    localparam int          BCFG_CTRL_ERASE = 0;
    localparam int          BCFG_CTRL_SWRST = 1;
    localparam int          BCFG_BSET_LIN   = 16;
    localparam int          BCFG_STAT_LOAD  = 0;
    localparam int          BCFG_STAT_LOCK  = 1;
    localparam int          BCFG_STAT_PERM  = 2;
    localparam int          BCFG_STAT_BUSY  = 3;

    // ------------------------------------------------------------------
    // Types
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        BCFG_WRAP_RSVD,
        BCFG_WRAP_64,
        BCFG_WRAP_16,
        BCFG_WRAP_32
    } bcfg_wrap_t;

    // One layout serves both registers
    typedef struct packed {
        logic       rsv15;
        logic [2:0] drive;
        logic       freeze;
        logic       ssr_freeze;
        logic [1:0] sector_map;
        logic [3:0] latency;
        logic       rsv3;
        logic       no_stall;
        bcfg_wrap_t wrap;
    } bcfg_cfg_t;

    typedef struct packed {
        logic        cyc;
        logic        stb;
        logic        we;
        logic [3:0]  sel;
        logic [7:0]  adr;
        logic [31:0] dat;
    } bcfg_wb_req_t;

    // Byte-lane merge of a 16-bit register, reserved bits forced high
    function automatic logic [15:0] bcfg_merge16(input logic [15:0] old_val,
                                                 input logic [31:0] wdat,
                                                 input logic [3:0]  sel);
        logic [15:0] r;
        r = old_val;
        if (sel[0]) r[7:0] = wdat[7:0];
        if (sel[1]) r[15:8] = wdat[15:8];
        return r | BCFG_RSV_ONES;
    endfunction

endpackage

// ===== rtl/bcfg_sync.sv
// Two-stage synchroniser for link pins.
// Assumes inputs are asynchronous to clk; only stage two is read outside.
module bcfg_sync import bcfg_pkg::*; #(
    parameter int          W   = 2,
    parameter logic [W-1:0] RST = '0
) (
    // Clock and reset
    input  wire logic         clk,
    input  wire logic         rst,
    // Pins and synchronised copy
    input  wire logic [W-1:0] pin_in,
    output logic      [W-1:0] sync_out
);

    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
    } bcfg_sync_state_t;

    bcfg_sync_state_t st_reg;
    bcfg_sync_state_t st_next;

    // Stage one feeds stage two only
    always_comb begin
        st_next = st_reg;
        st_next.s1 = pin_in;
        st_next.s2 = st_reg.s1;
        if (rst) begin
            st_next.s1 = RST;
            st_next.s2 = RST;
        end
    end

    always_ff @(posedge clk) begin
        st_reg <= st_next;
    end

    assign sync_out = st_reg.s2;

endmodule

// ===== rtl/bcfg_burst.sv
// Word address sequencer for wrapped and linear bursts.
// Assumes load and step are one-cycle pulses on clk and never coincide.
module bcfg_burst import bcfg_pkg::*; (
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        rst,
    // Control
    input  wire logic        load,
    input  wire logic        step,
    input  wire logic [15:0] start,
    input  wire logic        linear,
    input  wire bcfg_wrap_t  wrap,
    // Current word address
    output logic      [15:0] word
);

    typedef struct packed {
        logic [15:0] word;
    } bcfg_burst_state_t;

    bcfg_burst_state_t st_reg;
    bcfg_burst_state_t st_next;

    // Next word: low bits roll within the aligned group, upper bits hold
    function automatic logic [15:0] next_word(input logic [15:0] a,
                                              input logic        lin,
                                              input bcfg_wrap_t  w);
        logic [15:0] m;
        logic [15:0] inc;
        inc = a + 16'h0001;
        case (w)
            BCFG_WRAP_16: m = 16'h0007;
            BCFG_WRAP_32: m = 16'h000f;
            BCFG_WRAP_64: m = 16'h001f;
            default:      m = 16'hffff; // Reserved code runs linear
        endcase
        if (lin) m = 16'hffff;
        return (a & ~m) | (inc & m);
    endfunction

    // Load wins over step so a new burst starts clean
    always_comb begin
        st_next = st_reg;
        if (rst) st_next.word = BCFG_WORD_RST;
        else if (load) st_next.word = start;
        else if (step) st_next.word = next_word(st_reg.word, linear, wrap);
    end

    always_ff @(posedge clk) begin
        st_reg <= st_next;
    end

    assign word = st_reg.word;

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    property p_wrap16_group;
        @(posedge clk) disable iff (rst)
        step && !load && !linear && wrap == BCFG_WRAP_16 |=>
            word[15:3] == $past(word[15:3]) && word[2:0] == $past(word[2:0]) + 3'h1;
    endproperty
    a_wrap16_group: assert property (p_wrap16_group) else $error("16-byte wrap left its group");

    property p_linear_step;
        @(posedge clk) disable iff (rst)
        step && !load && linear |=> word == $past(word) + 16'h0001;
    endproperty
    a_linear_step: assert property (p_linear_step) else $error("linear burst did not increment");

endmodule

// ===== rtl/bcfg_top.sv
// Bus configuration register bank with Wishbone classic slave.
// Assumes por is held at start-up; link pins are asynchronous to clk.
module bcfg_top import bcfg_pkg::*; (
    // Clock and resets
    input  wire logic         clk,
    input  wire logic         rst,
    input  wire logic         por,
    // Wishbone classic slave
    input  wire bcfg_wb_req_t wb_req,
    output logic              wb_ack,
    output logic       [31:0] wb_dat,
    // Flash link pins
    input  wire logic         link_ck_pin,
    input  wire logic         link_cs_n_pin,
    // Device-side inputs
    input  wire logic         ecc_dual_err,
    // Configuration decode to the device
    output logic       [2:0]  drive_strength,
    output logic       [1:0]  sector_map,
    output logic       [4:0]  latency_clocks,
    output logic              read_data_strobe_stall,
    output logic              secure_silicon_region_prog_ok,
    output bcfg_wrap_t        wrap_len,
    output logic              using_volatile,
    output logic       [15:0] burst_word
);

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    typedef struct packed {
        bcfg_cfg_t   nonvol;
        bcfg_cfg_t   vol;
        logic        vol_loaded;
        logic        perm_lock;
        logic [15:0] start;
        logic        linear;
        logic        ack;
        logic [31:0] dat;
        logic        cs_prev;
        logic        ck_prev;
        logic [2:0]  drive;
        logic [1:0]  map;
        logic [4:0]  lat;
        logic        stall;
        logic        ssr_ok;
        bcfg_wrap_t  wrap;
    } bcfg_top_state_t;

    bcfg_top_state_t st_reg;
    bcfg_top_state_t st_next;

    logic [1:0]  pins_sync;
    logic        cs_n_s;
    logic        ck_s;
    logic [15:0] word_cur;
    bcfg_cfg_t   active;
    logic        locked;
    logic        idle;
    logic        req;
    logic        wr_take;
    logic [15:0] wr_vol_val;
    logic [15:0] wr_nv_val;
    logic        wr_vol;
    logic        wr_nv;
    logic        wr_ctrl;
    logic        erase_ok;
    logic        swrst;
    logic        burst_load;
    logic        burst_step;

    // ------------------------------------------------------------------
    // Link pin synchronisers and burst sequencer
    // ------------------------------------------------------------------
    bcfg_sync #(
        .W   (2),
        .RST (2'b10)
    ) u_sync (
        .clk      (clk),
        .rst      (rst || por),
        .pin_in   ({link_cs_n_pin, link_ck_pin}),
        .sync_out (pins_sync)
    );

    assign cs_n_s = pins_sync[1];
    assign ck_s   = pins_sync[0];

    // Burst opens on chip select falling, advances on each link clock rise
    assign burst_load = st_reg.cs_prev && !cs_n_s;
    assign burst_step = !cs_n_s && !st_reg.cs_prev && ck_s && !st_reg.ck_prev;

    bcfg_burst u_burst (
        .clk    (clk),
        .rst    (rst || por),
        .load   (burst_load),
        .step   (burst_step),
        .start  (st_reg.start),
        .linear (st_reg.linear),
        .wrap   (active.wrap),
        .word   (word_cur)
    );

    // ------------------------------------------------------------------
    // Decode helpers
    // ------------------------------------------------------------------
    // Volatile register rules once loaded; reset brings control back
    assign active  = st_reg.vol_loaded ? st_reg.vol : st_reg.nonvol;
    // After reset both freeze bits agree, so the volatile bit decides
    assign locked  = !st_reg.vol.freeze;
    assign idle    = cs_n_s && st_reg.cs_prev;
    assign req     = wb_req.cyc && wb_req.stb;
    // Writes land at the edge where the master sees ack high
    assign wr_take = req && wb_req.we && st_reg.ack;
    assign wr_vol_val = bcfg_merge16(st_reg.vol, wb_req.dat, wb_req.sel);
    assign wr_nv_val  = bcfg_merge16(st_reg.nonvol, wb_req.dat, wb_req.sel);
    assign wr_vol   = wr_take && wb_req.adr == BCFG_OFS_VOL && !locked && idle;
    assign wr_nv    = wr_take && wb_req.adr == BCFG_OFS_NONVOL && !locked && idle;
    assign wr_ctrl  = wr_take && wb_req.adr == BCFG_OFS_CTRL && wb_req.sel[0];
    assign erase_ok = wr_ctrl && wb_req.dat[BCFG_CTRL_ERASE] && !locked && idle;
    assign swrst    = wr_ctrl && wb_req.dat[BCFG_CTRL_SWRST];

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    always_comb begin
        st_next = st_reg;
        st_next.cs_prev = cs_n_s;
        st_next.ck_prev = ck_s;

        // Classic single cycle: ack for one cycle, then drop
        st_next.ack = req && !st_reg.ack;
        if (req && !st_reg.ack) begin
            case (wb_req.adr)
                BCFG_OFS_NONVOL: st_next.dat = {16'h0000, st_reg.nonvol};
                BCFG_OFS_VOL:    st_next.dat = {16'h0000, st_reg.vol};
                BCFG_OFS_STAT: begin
                    st_next.dat = 32'h0000_0000;
                    st_next.dat[BCFG_STAT_LOAD] = st_reg.vol_loaded;
                    st_next.dat[BCFG_STAT_LOCK] = locked;
                    st_next.dat[BCFG_STAT_PERM] = st_reg.perm_lock;
                    st_next.dat[BCFG_STAT_BUSY] = !idle;
                end
                BCFG_OFS_BSET:   st_next.dat = {15'h0000, st_reg.linear, st_reg.start};
                BCFG_OFS_BADDR:  st_next.dat = {16'h0000, word_cur};
                default:         st_next.dat = 32'h0000_0000; // Control and unmapped read zero
            endcase
        end

        // Volatile load switches the source until the next reset
        if (wr_vol) begin
            st_next.vol = bcfg_cfg_t'(wr_vol_val);
            st_next.vol_loaded = 1'b1;
        end

        // Programming: copy into an unloaded volatile register, keep its freeze
        if (wr_nv) begin
            st_next.nonvol = bcfg_cfg_t'(wr_nv_val);
            if (!st_reg.vol_loaded) begin
                st_next.vol = bcfg_cfg_t'(wr_nv_val);
                st_next.vol.freeze = st_reg.vol.freeze;
            end
        end

        // Erase brings the cells back to all ones; volatile untouched
        if (erase_ok) st_next.nonvol = bcfg_cfg_t'(BCFG_ERASED);

        // Software reset only reaches the link-facing state
        if (swrst) begin
            st_next.cs_prev = 1'b1;
        end

        if (wr_take && wb_req.adr == BCFG_OFS_BSET) begin
            if (wb_req.sel[0]) st_next.start[7:0] = wb_req.dat[7:0];
            if (wb_req.sel[1]) st_next.start[15:8] = wb_req.dat[15:8];
            if (wb_req.sel[2]) st_next.linear = wb_req.dat[BCFG_BSET_LIN];
        end

        // Registered decode of the active configuration
        st_next.drive  = active.drive;
        st_next.map    = active.sector_map;
        st_next.lat    = {1'b0, active.latency} + BCFG_LAT_BASE;
        st_next.stall  = ecc_dual_err && !active.no_stall && !cs_n_s;
        st_next.ssr_ok = active.ssr_freeze;
        st_next.wrap   = active.wrap;

        // Power-up restores factory cells; hardware reset keeps them
        if (por || rst) begin
            st_next = '0;
            st_next.nonvol = por ? bcfg_cfg_t'(BCFG_FACTORY) : st_reg.nonvol;
            st_next.vol = st_next.nonvol;
            st_next.vol_loaded = 1'b0;
            st_next.perm_lock = !st_next.nonvol.freeze;
            st_next.cs_prev = 1'b1;
            st_next.wrap = BCFG_WRAP_RSVD;
        end
    end

    always_ff @(posedge clk) begin
        st_reg <= st_next;
    end

    // ------------------------------------------------------------------
    // Outputs, all straight from flops
    // ------------------------------------------------------------------
    assign wb_ack                        = st_reg.ack;
    assign wb_dat                        = st_reg.dat;
    assign drive_strength                = st_reg.drive;
    assign sector_map                    = st_reg.map;
    assign latency_clocks                = st_reg.lat;
    assign read_data_strobe_stall        = st_reg.stall;
    assign secure_silicon_region_prog_ok = st_reg.ssr_ok;
    assign wrap_len                      = st_reg.wrap;
    assign using_volatile                = st_reg.vol_loaded;
    assign burst_word                    = word_cur;

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst || por);

    sequence s_vol_load;
        wr_vol && wb_req.sel[1:0] == 2'b11;
    endsequence

    sequence s_after_reset;
        $past(rst) || $past(por);
    endsequence

    property p_reset_source;
        s_after_reset |-> !st_reg.vol_loaded && st_reg.vol == st_reg.nonvol;
    endproperty
    a_reset_source: assert property (p_reset_source) else $error("reset did not restore non-volatile control");

    property p_loaded_sticks;
        st_reg.vol_loaded |=> st_reg.vol_loaded;
    endproperty
    a_loaded_sticks: assert property (p_loaded_sticks) else $error("volatile selection dropped without reset");

    property p_swrst_keeps_select;
        swrst |=> using_volatile == $past(using_volatile);
    endproperty
    a_swrst_keeps_select: assert property (p_swrst_keeps_select) else $error("software reset moved the selector");

    property p_vol_acts;
        s_vol_load ##1 1 |=> drive_strength == $past(wb_req.dat[14:12], 2) && using_volatile;
    endproperty
    a_vol_acts: assert property (p_vol_acts) else $error("volatile load did not reach the drivers");

    property p_nv_keeps_loaded_vol;
        (wr_nv || erase_ok) && st_reg.vol_loaded && !wr_vol |=> $stable(st_reg.vol);
    endproperty
    a_nv_keeps_loaded_vol: assert property (p_nv_keeps_loaded_vol) else $error("volatile changed by non-volatile");

    property p_nv_copies;
        wr_nv && !st_reg.vol_loaded |=> st_reg.vol[10:0] == st_reg.nonvol[10:0];
    endproperty
    a_nv_copies: assert property (p_nv_copies) else $error("unloaded volatile not copied");

    property p_latency;
        ##1 1 |-> latency_clocks == {1'b0, $past(active.latency)} + 5'h05;
    endproperty
    a_latency: assert property (p_latency) else $error("latency decode is not code plus five");

    property p_reserved_ones;
        st_reg.vol.rsv15 && st_reg.vol.rsv3 && st_reg.nonvol.rsv15 && st_reg.nonvol.rsv3;
    endproperty
    a_reserved_ones: assert property (p_reserved_ones) else $error("reserved bit read zero");

    property p_stall;
        ecc_dual_err && !active.no_stall && !cs_n_s |=> read_data_strobe_stall;
    endproperty
    a_stall: assert property (p_stall) else $error("strobe not held after dual error");

    property p_frozen_ignores;
        locked && wr_take |=> $stable(st_reg.vol) && $stable(st_reg.nonvol);
    endproperty
    a_frozen_ignores: assert property (p_frozen_ignores) else $error("frozen register changed");

    property p_perm_lock;
        st_reg.perm_lock |-> !st_reg.vol.freeze && !st_reg.nonvol.freeze;
    endproperty
    a_perm_lock: assert property (p_perm_lock) else $error("permanent lock opened");

    property p_ack_one;
        wb_ack |=> !wb_ack;
    endproperty
    a_ack_one: assert property (p_ack_one) else $error("ack held two cycles");

    // Raw source word read by bit position, so a layout slip shows up
    logic [15:0] src_word;
    assign src_word = st_reg.vol_loaded ? st_reg.vol : st_reg.nonvol;

    // Decoded outputs trail the source register by one clock
    property p_drive_decode;
        1'b1 |=> drive_strength == $past(src_word[14:12]);
    endproperty
    a_drive_decode: assert property (p_drive_decode) else $error("drive code misplaced");

    property p_ssr_decode;
        1'b1 |=> secure_silicon_region_prog_ok == $past(src_word[10]);
    endproperty
    a_ssr_decode: assert property (p_ssr_decode) else $error("secure region bit misplaced");

    property p_map_decode;
        1'b1 |=> sector_map == $past(src_word[9:8]);
    endproperty
    a_map_decode: assert property (p_map_decode) else $error("sector map misplaced");

    property p_wrap_decode;
        1'b1 |=> wrap_len == $past(src_word[1:0]);
    endproperty
    a_wrap_decode: assert property (p_wrap_decode) else $error("wrap code misplaced");

    // Strobe never stalls once the stall control bit is set
    property p_no_stall;
        active.no_stall |=> !read_data_strobe_stall;
    endproperty
    a_no_stall: assert property (p_no_stall) else $error("strobe stalled while disabled");

    // A locked image at reset locks both registers until a power-up reset
    property p_perm_after_reset;
        s_after_reset ##0 !st_reg.nonvol.freeze |-> st_reg.perm_lock && locked;
    endproperty
    a_perm_after_reset: assert property (p_perm_after_reset) else $error("lock lost at reset");

    // Programming an unloaded copy keeps its freeze bit until reset
    property p_temp_unlock;
        wr_nv && !st_reg.vol_loaded |=> st_reg.vol.freeze == $past(st_reg.vol.freeze);
    endproperty
    a_temp_unlock: assert property (p_temp_unlock) else $error("freeze copied too early");

    // Writes while the link is busy change neither register
    property p_busy_refused;
        wr_take && !idle |=> $stable(st_reg.vol) && $stable(st_reg.nonvol);
    endproperty
    a_busy_refused: assert property (p_busy_refused) else $error("busy write landed");

    // A new frame starts at the programmed word
    property p_burst_start;
        burst_load |=> burst_word == $past(st_reg.start);
    endproperty
    a_burst_start: assert property (p_burst_start) else $error("burst did not start at setup word");

endmodule

// ===== bench/bcfg_link_model.sv
// Host controller model for the flash link pins.
// Assumes the bench calls its tasks; link clock stands still outside frames.
module bcfg_link_model (
    // Link pins towards the block
    output logic ck,
    output logic cs_n
);
    timeunit 1ns;
    timeprecision 1ps;

    // Idle: deselected, clock parked low
    initial begin
        ck   = 1'b0;
        cs_n = 1'b1;
    end

    // Odd offset keeps the frame out of phase with clk
    task automatic open();
        #37 cs_n = 1'b0;
        #200;
    endtask

    // One 200 ns link clock period
    task automatic pulse();
        ck = 1'b1;
        #100 ck = 1'b0;
        #100;
    endtask

    // Long tail so the block sees idle before the next load
    task automatic close();
        #50 cs_n = 1'b1;
        #200;
    endtask
endmodule

// ===== bench/tb_top.sv
// Self-checking bench for the bus configuration register bank.
// Assumes a Wishbone classic master and the link model at the far side.
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import bcfg_pkg::*;

    logic         clk, rst, por, ecc, ack, ck, cs_n, stall, ssr_ok, usev;
    logic  [2:0]  drv;
    logic  [1:0]  map;
    logic  [4:0]  lat;
    logic  [15:0] word;
    logic  [31:0] dat, q;
    bcfg_wrap_t   wrap;
    bcfg_wb_req_t req;
    int           bad_count, checked;

    bcfg_link_model i_host (.ck(ck), .cs_n(cs_n));

    bcfg_top i_dut (.clk(clk), .rst(rst), .por(por), .wb_req(req), .wb_ack(ack), .wb_dat(dat),
        .link_ck_pin(ck), .link_cs_n_pin(cs_n), .ecc_dual_err(ecc), .drive_strength(drv),
        .sector_map(map), .latency_clocks(lat), .read_data_strobe_stall(stall),
        .secure_silicon_region_prog_ok(ssr_ok), .wrap_len(wrap), .using_volatile(usev),
        .burst_word(word));

    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            bad_count++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // Request held until ack is seen at a rising edge
    task automatic wb(input logic [7:0] a, input logic w, input logic [31:0] d);
        int n;
        @(posedge clk);
        req <= '{1'b1, 1'b1, w, 4'hf, a, d};
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (ack !== 1'b1 && n < 50);
        q = dat;
        req <= '0;
        if (ack !== 1'b1) chk(32'h0, 32'h1);
    endtask

    task automatic rd(input logic [7:0] a, input logic [15:0] e);
        wb(a, 1'b0, 32'h0);
        chk(q, {16'h0, e});
    endtask

    // Decoded outputs trail the register by one cycle; the task waits three
    task automatic outs(input logic [2:0] d, input logic [1:0] m, input logic [4:0] l,
                        input logic s, input bcfg_wrap_t w, input logic u);
        repeat (3) @(posedge clk);
        #1;
        chk({drv, map, lat, ssr_ok, wrap, usev}, {d, m, l, s, w, u});
    endtask

    task automatic reset_dut(input logic p);
        @(posedge clk);
        if (p) por <= 1'b1;
        else rst <= 1'b1;
        repeat (6) @(posedge clk);
        por <= 1'b0;
        rst <= 1'b0;
    endtask

    // Expected word worked out from start, mode and group mask
    task automatic burst(input logic [15:0] st, input logic lin, input int n, input logic [15:0] m);
        logic [15:0] e;
        wb(BCFG_OFS_BSET, 1'b1, {15'h0, lin, st});
        i_host.open();
        for (int k = 0; k <= n; k++) begin
            e = lin ? st + k : (st & ~m) | ((st + k) & m);
            chk(word, e);
            if (k < n) i_host.pulse();
        end
        i_host.close();
    endtask

    task automatic summarize();
        if (bad_count == 0 && checked > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_defaults();
        rd(BCFG_OFS_NONVOL, 16'h8ebb);
        rd(BCFG_OFS_VOL, 16'h8ebb);
        outs(3'h0, 2'h2, 5'h10, 1'b1, BCFG_WRAP_32, 1'b0);
    endtask

    // Volatile is loaded before the second program step so that step keeps bus settings
    task automatic t_regs();
        wb(BCFG_OFS_NONVOL, 1'b1, 32'h1cbb);
        rd(BCFG_OFS_VOL, 16'h9cbb);
        wb(BCFG_OFS_VOL, 1'b1, 32'h2a52);
        rd(BCFG_OFS_VOL, 16'haa5a);
        outs(3'h2, 2'h2, 5'h0a, 1'b0, BCFG_WRAP_16, 1'b1);
        wb(BCFG_OFS_NONVOL, 1'b1, 32'h07bb);
        rd(BCFG_OFS_NONVOL, 16'h87bb);
        rd(BCFG_OFS_VOL, 16'haa5a);
        wb(BCFG_OFS_CTRL, 1'b1, 32'h0002);
        outs(3'h2, 2'h2, 5'h0a, 1'b0, BCFG_WRAP_16, 1'b1);
    endtask

    task automatic t_link();
        burst(16'h0002, 1'b0, 8, 16'h0007);
        burst(16'h000c, 1'b0, 8, 16'h0007);
        burst(16'h0003, 1'b1, 20, 16'h0000);
        rd(BCFG_OFS_BADDR, 16'h0017);
        for (int i = 0; i < 2; i++) begin
            wb(BCFG_OFS_VOL, 1'b1, i ? 32'h2a56 : 32'h2a52);
            i_host.open();
            @(posedge clk);
            ecc <= 1'b1;
            repeat (5) @(posedge clk);
            ecc <= 1'b0;
            #1;
            chk(stall, i == 0);
            i_host.close();
        end
        // Wider groups, then a load refused while the link is busy
        wb(BCFG_OFS_VOL, 1'b1, 32'h2a57);
        burst(16'h000a, 1'b0, 16, 16'h000f);
        i_host.open();
        wb(BCFG_OFS_VOL, 1'b1, 32'h2a55);
        i_host.close();
        rd(BCFG_OFS_VOL, 16'haa5f);
        wb(BCFG_OFS_VOL, 1'b1, 32'h2a55);
        burst(16'h002e, 1'b0, 32, 16'h001f);
        rd(BCFG_OFS_BADDR, 16'h002e);
    endtask

    // Freeze bit programmed to zero locks both after hardware reset
    task automatic t_lock();
        reset_dut(1'b0);
        outs(3'h0, 2'h3, 5'h10, 1'b1, BCFG_WRAP_32, 1'b0);
        rd(BCFG_OFS_VOL, 16'h87bb);
        rd(BCFG_OFS_STAT, 16'h0006);
        wb(BCFG_OFS_VOL, 1'b1, 32'h2a52);
        rd(BCFG_OFS_VOL, 16'h87bb);
        wb(BCFG_OFS_CTRL, 1'b1, 32'h0001);
        wb(BCFG_OFS_NONVOL, 1'b1, 32'h1cbb);
        rd(BCFG_OFS_NONVOL, 16'h87bb);
        reset_dut(1'b1);
        rd(BCFG_OFS_NONVOL, 16'h8ebb);
        wb(BCFG_OFS_VOL, 1'b1, 32'h2a52);
        rd(BCFG_OFS_VOL, 16'haa5a);
        wb(BCFG_OFS_CTRL, 1'b1, 32'h0001);
        rd(BCFG_OFS_NONVOL, 16'hffff);
        rd(BCFG_OFS_VOL, 16'haa5a);
    endtask

    // ------------------------------------------------------------
    // Clock, sequence and watchdog
    // ------------------------------------------------------------
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    initial begin
        rst = 1'b1;
        por = 1'b1;
        ecc = 1'b0;
        req = '0;
        bad_count = 0;
        checked = 0;
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        por <= 1'b0;
        t_defaults();
        t_regs();
        t_link();
        t_lock();
        summarize();
    end

    // Whole run is some 25 us; this limit leaves ample margin
    initial begin
        #200000;
        bad_count++;
        summarize();
    end
endmodule
